//--- verilog/chgmc_top.sv
// Notes on behaviour
// [R1] A written one to the service bit restarts the watchdog count from zero.
// [R2] Watchdog timeout enters fault mode and switches the converter off.
// [R3] The service bit clears itself one cycle after being written to one.
// [R4] Timeout field picks 80, 160 or 320 s; value 00 disables the watchdog.
// [R5] In standby the watchdog never runs, whatever the timeout field says.
// [R6] Standby clears the count; leaving for charge or boost restarts counting.
// [R7] A host-less system must program the timeout field to 00.
// [R8] Charging after power-on starts in the phase the battery region selects.
// [R9] Charge mode is entered only from standby.
// [R10] Boost and charge requested together from standby: boost wins.
// [R11] The synchronised charge-request level requests or withdraws charge mode.
// [R12] Charge-force set enters charge regardless of the request pin.
// [R13] Standby-force set forces standby and blocks charge and boost.
// [R14] Boost pin and boost bit cannot end charge mode.
// [R15] Charge returns to standby only on pin low with force clear, or standby-force.
// [R16] Charge to boost always passes through standby.
// [R17] Entering storage mode ends charging unconditionally.
// [R18] Charge current follows the battery voltage region.
// [R19] Fast current is the scale value in percent of the hardware maximum.
// [R20] The scale register stores any 7-bit value exactly as written.
// [R21] Scale zero reads zero while 1 percent is applied.
// [R22] Scale above 0x64 reads as written while 100 percent is applied.
// [R23] The watchdog counts seconds from a prescaled system clock tick.
// [R24] Request pins are synchronised before the mode controller uses them.
`timescale 1ns/1ps
module chgmc_top #(
  parameter int TICK_CYCLES = chgmc_pkg::CHGMC_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic charge_request_pin_i,
  input wire logic boost_out_request_n_i,
  input wire logic storage_request_i,
  input wire logic above_dead_batt_thresh_i,
  input wire logic above_short_batt_thresh_i,
  input wire logic above_low_batt_thresh_i,
  input wire logic above_termination_voltage_i,
  output chgmc_pkg::chgmc_state_t mode_o,
  output logic converter_en_o,
  output chgmc_pkg::chgmc_phase_t charge_phase_o,
  output logic [6:0] charge_pct_o,
  output logic dead_batt_current_o
);
  import chgmc_pkg::*;

  if (TICK_CYCLES < 2) begin : g_tick_chk
    $error("chgmc_top: TICK_CYCLES must be at least 2.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [6:0] pins_sync;
  logic chg_pin;
  logic boost_req_pin;
  logic ship_req;
  logic above_dead;
  logic above_short;
  logic above_low;
  logic above_term;

  chgmc_sync #(
    .WIDTH(7)
  ) u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i({charge_request_pin_i, ~boost_out_request_n_i, storage_request_i,
              above_dead_batt_thresh_i, above_short_batt_thresh_i,
              above_low_batt_thresh_i, above_termination_voltage_i}), // see [R24]
    .level_o(pins_sync)
  );

  assign {chg_pin, boost_req_pin, ship_req, above_dead, above_short, above_low,
          above_term} = pins_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic wd_service_reg;
  logic charge_force_reg;
  logic standby_force_reg;
  logic boost_force_reg;
  logic [7:0] system_config_reg;
  logic [6:0] charge_scale_reg;
  logic wr_mode;
  logic wr_cfg;
  logic wr_scale;

  assign wr_mode = reg_wr_i && (reg_addr_i == CHGMC_MODE_CONTROL_OFS);
  assign wr_cfg = reg_wr_i && (reg_addr_i == CHGMC_SYSTEM_CONFIG_OFS);
  assign wr_scale = reg_wr_i && (reg_addr_i == CHGMC_CHARGE_SCALE_OFS);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_service_reg <= CHGMC_MODE_CONTROL_RST[CHGMC_WD_SERVICE_POS];
      charge_force_reg <= CHGMC_MODE_CONTROL_RST[CHGMC_CHARGE_FORCE_POS];
      standby_force_reg <= CHGMC_MODE_CONTROL_RST[CHGMC_STANDBY_FORCE_POS];
      boost_force_reg <= CHGMC_MODE_CONTROL_RST[CHGMC_BOOST_FORCE_POS];
    end else if (wr_mode) begin
      wd_service_reg <= reg_wdata_i[CHGMC_WD_SERVICE_POS];
      charge_force_reg <= reg_wdata_i[CHGMC_CHARGE_FORCE_POS];
      standby_force_reg <= reg_wdata_i[CHGMC_STANDBY_FORCE_POS];
      boost_force_reg <= reg_wdata_i[CHGMC_BOOST_FORCE_POS];
    end else begin
      wd_service_reg <= 1'b0; // see [R3]
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      system_config_reg <= CHGMC_SYSTEM_CONFIG_RST;
    end else if (wr_cfg) begin
      system_config_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      charge_scale_reg <= CHGMC_CHARGE_SCALE_RST;
    end else if (wr_scale) begin
      charge_scale_reg <= reg_wdata_i[6:0]; // see [R20]
    end
  end

  // Read data is registered; unmapped offsets read zero.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        CHGMC_MODE_CONTROL_OFS: reg_rdata_o <= {4'h0, boost_force_reg, standby_force_reg,
                                                charge_force_reg, wd_service_reg};
        CHGMC_SYSTEM_CONFIG_OFS: reg_rdata_o <= system_config_reg;
        CHGMC_CHARGE_SCALE_OFS: reg_rdata_o <= {1'b0, charge_scale_reg}; // see [R21]
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog.

  logic [1:0] wd_sel;
  logic [8:0] wd_limit;
  logic [31:0] tick_cnt_reg;
  logic [8:0] wd_sec_reg;
  logic wd_active;
  logic wd_expire;
  logic tick;
  chgmc_state_t state_reg;
  chgmc_state_t state_next;

  assign wd_sel = system_config_reg[CHGMC_WD_SEL_POS +: 2];

  always_comb begin
    unique case (wd_sel)
      2'h1: wd_limit = CHGMC_WD_T1_S; // see [R4]
      2'h2: wd_limit = CHGMC_WD_T2_S;
      2'h3: wd_limit = CHGMC_WD_T3_S;
      default: wd_limit = 9'h000;
    endcase
  end

  // Runs only in charge or boost mode with a non-zero timeout code.
  assign wd_active = (wd_sel != CHGMC_WD_OFF) && // see [R4]
                     (state_reg == CHGMC_ST_CHARGE || state_reg == CHGMC_ST_BOOST); // see [R5]
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  assign wd_expire = wd_active && !wd_service_reg && (wd_sec_reg >= wd_limit);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (!wd_active || wd_service_reg || tick || state_next == CHGMC_ST_STANDBY) begin
      tick_cnt_reg <= 32'h0000_0000; // see [R23]
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_sec_reg <= 9'h000;
    end else if (!wd_active || state_next == CHGMC_ST_STANDBY) begin
      wd_sec_reg <= 9'h000; // see [R6]
    end else if (wd_service_reg) begin
      wd_sec_reg <= 9'h000; // see [R1]
    end else if (tick && wd_sec_reg < wd_limit) begin
      wd_sec_reg <= wd_sec_reg + 9'h001; // see [R23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode controller.

  logic boost_req;
  logic charge_req;

  assign boost_req = boost_req_pin || boost_force_reg;
  assign charge_req = chg_pin || charge_force_reg; // see [R11] see [R12]

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CHGMC_ST_STANDBY: begin
        if (ship_req) begin
          state_next = CHGMC_ST_STORAGE;
        end else if (standby_force_reg) begin
          state_next = CHGMC_ST_STANDBY; // see [R13]
        end else if (boost_req) begin
          state_next = CHGMC_ST_BOOST; // see [R10]
        end else if (charge_req) begin
          state_next = CHGMC_ST_CHARGE; // see [R9] see [R8]
        end
      end
      CHGMC_ST_CHARGE: begin
        if (ship_req) begin
          state_next = CHGMC_ST_STORAGE; // see [R17]
        end else if (wd_expire) begin
          state_next = CHGMC_ST_FAULT; // see [R2]
        end else if (standby_force_reg || !charge_req) begin
          state_next = CHGMC_ST_STANDBY; // see [R15] see [R14] see [R16]
        end
      end
      CHGMC_ST_BOOST: begin
        if (ship_req) begin
          state_next = CHGMC_ST_STORAGE;
        end else if (wd_expire) begin
          state_next = CHGMC_ST_FAULT; // see [R2]
        end else if (standby_force_reg || !boost_req) begin
          state_next = CHGMC_ST_STANDBY; // see [R13]
        end
      end
      CHGMC_ST_FAULT: begin
        if (ship_req) begin
          state_next = CHGMC_ST_STORAGE;
        end else if (standby_force_reg) begin
          state_next = CHGMC_ST_STANDBY;
        end
      end
      CHGMC_ST_STORAGE: begin
        if (!ship_req) begin
          state_next = CHGMC_ST_STANDBY;
        end
      end
      default: state_next = CHGMC_ST_STANDBY;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= CHGMC_ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mode_o = state_reg;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converter_en_o <= 1'b0;
    end else begin
      converter_en_o <= (state_next == CHGMC_ST_CHARGE) ||
                        (state_next == CHGMC_ST_BOOST); // see [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge current selection.

  chgmc_phase_t phase;
  logic [6:0] pct;

  chgmc_current u_current (
    .above_dead_i(above_dead),
    .above_short_i(above_short),
    .above_low_i(above_low),
    .above_term_i(above_term),
    .short_sel_i(system_config_reg[CHGMC_SHORT_SEL_POS +: 2]),
    .pre_sel_i(system_config_reg[CHGMC_PRE_SEL_POS +: 2]),
    .scale_i(charge_scale_reg),
    .phase_o(phase),
    .pct_o(pct)
  );

  // Current is applied only in charge mode; zero otherwise.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      charge_phase_o <= CHGMC_PH_DEAD;
      charge_pct_o <= 7'h00;
      dead_batt_current_o <= 1'b0;
    end else if (state_reg == CHGMC_ST_CHARGE) begin
      charge_phase_o <= phase; // see [R8]
      charge_pct_o <= pct; // see [R18]
      dead_batt_current_o <= (phase == CHGMC_PH_DEAD);
    end else begin
      charge_phase_o <= CHGMC_PH_DEAD;
      charge_pct_o <= 7'h00;
      dead_batt_current_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence svc_write_s;
    wr_mode && reg_wdata_i[CHGMC_WD_SERVICE_POS];
  endsequence

  sequence svc_done_s;
    wd_service_reg ##1 !wd_service_reg;
  endsequence

  svc_clear_a: assert property (svc_write_s ##1 !wr_mode |-> svc_done_s) // see [R3]
    else $error("Service bit did not clear itself.");
  svc_restart_a: assert property (svc_write_s |-> ##2 (wd_sec_reg == 9'h000)) // see [R1]
    else $error("Service write did not restart the watchdog.");
  wd_fault_a: assert property (state_reg == CHGMC_ST_CHARGE && wd_expire && !ship_req
                               |=> state_reg == CHGMC_ST_FAULT && !converter_en_o) // see [R2]
    else $error("Watchdog timeout did not reach fault mode.");
  wd_off_a: assert property (wd_sel == CHGMC_WD_OFF |-> !wd_expire ##1 wd_sec_reg == 9'h000) // see [R4]
    else $error("Watchdog ran with timeout code zero.");
  standby_wd_a: assert property (state_reg == CHGMC_ST_STANDBY
                                 |-> wd_sec_reg == 9'h000 && tick_cnt_reg == 32'h0) // see [R6]
    else $error("Watchdog not cleared in standby.");
  charge_entry_a: assert property (state_reg != CHGMC_ST_CHARGE ##1 state_reg == CHGMC_ST_CHARGE
                                   |-> $past(state_reg) == CHGMC_ST_STANDBY) // see [R9]
    else $error("Charge mode entered from a mode other than standby.");
  boost_prio_a: assert property (state_reg == CHGMC_ST_STANDBY && boost_req && charge_req &&
                                 !standby_force_reg && !ship_req
                                 |=> state_reg == CHGMC_ST_BOOST) // see [R10]
    else $error("Boost did not win over charge.");
  force_entry_a: assert property (state_reg == CHGMC_ST_STANDBY && charge_force_reg &&
                                  !boost_req && !standby_force_reg && !ship_req
                                  |=> state_reg == CHGMC_ST_CHARGE) // see [R12]
    else $error("Charge force did not enter charge mode.");
  standby_block_a: assert property (standby_force_reg && state_reg == CHGMC_ST_STANDBY
                                    |=> state_reg inside {CHGMC_ST_STANDBY,
                                                          CHGMC_ST_STORAGE}) // see [R13]
    else $error("Standby force did not block charge or boost.");
  charge_hold_a: assert property (state_reg == CHGMC_ST_CHARGE && charge_req &&
                                  !standby_force_reg && !ship_req && !wd_expire
                                  |=> state_reg == CHGMC_ST_CHARGE) // see [R15]
    else $error("Charge mode left without cause.");
  no_chg_boost_a: assert property (state_reg == CHGMC_ST_CHARGE
                                   |=> state_reg != CHGMC_ST_BOOST) // see [R16]
    else $error("Direct charge to boost transition.");
  storage_end_a: assert property (state_reg == CHGMC_ST_CHARGE && ship_req
                                  |=> state_reg == CHGMC_ST_STORAGE ##1 charge_pct_o == 7'h00) // see [R17]
    else $error("Storage request did not end charging.");
  fast_clamp_a: assert property (state_reg == CHGMC_ST_CHARGE && phase == CHGMC_PH_FAST
                                 |=> charge_pct_o == (($past(charge_scale_reg) == 7'h00) ?
                                     CHGMC_PCT_MIN : ($past(charge_scale_reg) > CHGMC_PCT_MAX) ?
                                     CHGMC_PCT_MAX : $past(charge_scale_reg))) // see [R22]
    else $error("Fast charge percentage not clamped.");

endmodule : chgmc_top

//--- verilog/chgmc_pkg.sv
package chgmc_pkg;

  // Register offsets.
  localparam logic [7:0] CHGMC_MODE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CHGMC_SYSTEM_CONFIG_OFS = 8'h01;
  localparam logic [7:0] CHGMC_CHARGE_SCALE_OFS = 8'h18;

  // Field positions in mode_control.
  localparam int CHGMC_WD_SERVICE_POS = 0;
  localparam int CHGMC_CHARGE_FORCE_POS = 1;
  localparam int CHGMC_STANDBY_FORCE_POS = 2;
  localparam int CHGMC_BOOST_FORCE_POS = 3;

  // Field positions in system_config.
  localparam int CHGMC_WD_SEL_POS = 0;
  localparam int CHGMC_SHORT_SEL_POS = 2;
  localparam int CHGMC_PRE_SEL_POS = 4;

  // Values after reset.
  localparam logic [7:0] CHGMC_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] CHGMC_SYSTEM_CONFIG_RST = 8'h00;
  localparam logic [6:0] CHGMC_CHARGE_SCALE_RST = 7'h64;

  // Watchdog timeout codes and periods in seconds.
  localparam logic [1:0] CHGMC_WD_OFF = 2'h0;
  localparam logic [8:0] CHGMC_WD_T1_S = 9'd80;
  localparam logic [8:0] CHGMC_WD_T2_S = 9'd160;
  localparam logic [8:0] CHGMC_WD_T3_S = 9'd320;

  // Clock rate and the one second watchdog tick.
  localparam longint CHGMC_CLK_HZ = 50_000_000;
  localparam longint CHGMC_TICK_S = 1;
  localparam int CHGMC_TICK_CYCLES = int'(CHGMC_CLK_HZ * CHGMC_TICK_S);

  // Charge current percentages.
  localparam logic [6:0] CHGMC_PCT_MIN = 7'h01;
  localparam logic [6:0] CHGMC_PCT_MAX = 7'h64;
  localparam logic [6:0] CHGMC_PRE_STEP = 7'h05;

  // Charge phases by battery voltage region.
  typedef enum logic [2:0] {
    CHGMC_PH_DEAD = 3'h0,
    CHGMC_PH_SHORT = 3'h1,
    CHGMC_PH_PRE = 3'h2,
    CHGMC_PH_FAST = 3'h3,
    CHGMC_PH_DONE = 3'h4
  } chgmc_phase_t;

  // Operating modes, one-hot.
  typedef enum logic [4:0] {
    CHGMC_ST_STANDBY = 5'b00001,
    CHGMC_ST_CHARGE = 5'b00010,
    CHGMC_ST_BOOST = 5'b00100,
    CHGMC_ST_FAULT = 5'b01000,
    CHGMC_ST_STORAGE = 5'b10000
  } chgmc_state_t;

endpackage : chgmc_pkg

//--- verilog/chgmc_sync.sv
`timescale 1ns/1ps
module chgmc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;

  if (WIDTH < 1) begin : g_width_chk
    $error("chgmc_sync: WIDTH must be at least 1.");
  end

  // Three stages; a bit changes once the last two stages agree.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      level_o <= '0;
    end else begin
      ff1_reg <= async_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (ff2_reg[i] == ff3_reg[i]) begin
          level_o[i] <= ff3_reg[i];
        end
      end
    end
  end

endmodule : chgmc_sync

//--- verilog/chgmc_current.sv
`timescale 1ns/1ps
module chgmc_current (
  input wire logic above_dead_i,
  input wire logic above_short_i,
  input wire logic above_low_i,
  input wire logic above_term_i,
  input wire logic [1:0] short_sel_i,
  input wire logic [1:0] pre_sel_i,
  input wire logic [6:0] scale_i,
  output chgmc_pkg::chgmc_phase_t phase_o,
  output logic [6:0] pct_o
);
  import chgmc_pkg::*;

  // Picks the phase and the share of the hardware maximum.
  always_comb begin
    phase_o = CHGMC_PH_DEAD;
    pct_o = 7'h00;
    if (above_term_i) begin
      phase_o = CHGMC_PH_DONE; // see [R18]
    end else if (above_low_i) begin
      phase_o = CHGMC_PH_FAST;
      if (scale_i == 7'h00) begin
        pct_o = CHGMC_PCT_MIN; // see [R21]
      end else if (scale_i > CHGMC_PCT_MAX) begin
        pct_o = CHGMC_PCT_MAX; // see [R22]
      end else begin
        pct_o = scale_i; // see [R19]
      end
    end else if (above_short_i) begin
      phase_o = CHGMC_PH_PRE;
      pct_o = 7'(CHGMC_PRE_STEP * ({5'h00, pre_sel_i} + 7'h01)); // see [R18]
    end else if (above_dead_i) begin
      phase_o = CHGMC_PH_SHORT;
      pct_o = 7'(7'h01 << short_sel_i); // see [R18]
    end
  end

endmodule : chgmc_current

//--- verification/chgmc_host.sv
`timescale 1ns/1ps
module chgmc_host (
  input wire logic clock_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  ////////////////////////////////////////
  // Writes one byte; the data lines show other values once released.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask : wr
  // Reads one byte; the answer stands after the read edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask : rd
  // A host-less setup leaves the watchdog off.
  task automatic standalone_cfg();
    wr(8'h01, 8'h00);
  endtask : standalone_cfg
endmodule : chgmc_host

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import chgmc_pkg::*;
  logic clock_i, rst_b_i, reg_wr, reg_rd, chg_pin, boost_n, storage;
  logic a_dead, a_short, a_low, a_term, conv_en, dead_cur;
  logic [7:0] addr, wdata, rdata, v;
  logic [6:0] pct;
  chgmc_state_t mode;
  chgmc_phase_t phase;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] sv [5] = '{8'h00, 8'h4b, 8'h64, 8'h65, 8'hff};
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  chgmc_top #(.TICK_CYCLES(10)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .charge_request_pin_i(chg_pin), .boost_out_request_n_i(boost_n),
    .storage_request_i(storage), .above_dead_batt_thresh_i(a_dead),
    .above_short_batt_thresh_i(a_short), .above_low_batt_thresh_i(a_low),
    .above_termination_voltage_i(a_term), .mode_o(mode), .converter_en_o(conv_en),
    .charge_phase_o(phase), .charge_pct_o(pct), .dead_batt_current_o(dead_cur));
  chgmc_host host (.clock_i(clock_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  ////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_mode(input chgmc_state_t e);
    n_compared++;
    if (mode !== e) begin
      failures++;
      $display("BAD mode expected %b seen %b", e, mode);
    end
  endtask : chk_mode
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk("register", e, d);
  endtask : chk_reg
  task automatic wait_mode(input chgmc_state_t e);
    int i;
    for (i = 0; i < 2000 && mode !== e; i++) begin
      @(negedge clock_i);
    end
    chk_mode(e);
    if (i == 2000) begin
      summarize();
    end
  endtask : wait_mode
  task automatic settle_chk(input chgmc_phase_t ph, input logic [7:0] p);
    repeat (8) @(negedge clock_i);
    chk("phase", {5'h00, ph}, {5'h00, phase});
    chk("percent", p, {1'b0, pct});
  endtask : settle_chk
  ////////////////////////////////////////
  initial begin
    {rst_b_i, chg_pin, storage, a_term} = 4'h0;
    {boost_n, a_dead, a_short, a_low} = 4'hf;
    repeat (12) @(negedge clock_i);
    rst_b_i = 1'b1;
    chk_mode(CHGMC_ST_STANDBY);
    chk_reg(8'h00, 8'h00);
    chk_reg(8'h01, 8'h00);
    chk_reg(8'h18, 8'h64);
    host.wr(8'h05, 8'hff);
    chk_reg(8'h05, 8'h00);
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h18, sv[i]);
      chk_reg(8'h18, sv[i] & 8'h7f);
    end
    $display("test registers done");
    host.standalone_cfg();
    chg_pin = 1'b1;
    wait_mode(CHGMC_ST_CHARGE);
    chk("converter", 8'h01, {7'h00, conv_en});
    for (int i = 0; i < 5; i++) begin
      v = sv[i] & 8'h7f;
      host.wr(8'h18, v);
      v = (v == 8'h00) ? 8'h01 : ((v > 8'h64) ? 8'h64 : v);
      settle_chk(CHGMC_PH_FAST, v);
    end
    a_low = 1'b0;
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h01, 8'(k << 4));
      settle_chk(CHGMC_PH_PRE, 8'(5 * (k + 1)));
    end
    a_short = 1'b0;
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h01, 8'(k << 2));
      settle_chk(CHGMC_PH_SHORT, 8'(1 << k));
    end
    a_dead = 1'b0;
    settle_chk(CHGMC_PH_DEAD, 8'h00);
    chk("dead current", 8'h01, {7'h00, dead_cur});
    {a_dead, a_short, a_low, a_term} = 4'hf;
    settle_chk(CHGMC_PH_DONE, 8'h00);
    a_term = 1'b0;
    $display("test currents done");
    boost_n = 1'b0;
    host.wr(8'h00, 8'h08);
    repeat (20) @(negedge clock_i);
    chk_mode(CHGMC_ST_CHARGE);
    host.wr(8'h00, 8'h00);
    chg_pin = 1'b0;
    wait_mode(CHGMC_ST_STANDBY);
    wait_mode(CHGMC_ST_BOOST);
    boost_n = 1'b1;
    wait_mode(CHGMC_ST_STANDBY);
    host.wr(8'h00, 8'h02);
    wait_mode(CHGMC_ST_CHARGE);
    host.wr(8'h00, 8'h04);
    wait_mode(CHGMC_ST_STANDBY);
    chg_pin = 1'b1;
    boost_n = 1'b0;
    repeat (20) @(negedge clock_i);
    chk_mode(CHGMC_ST_STANDBY);
    host.wr(8'h00, 8'h00);
    wait_mode(CHGMC_ST_BOOST);
    boost_n = 1'b1;
    wait_mode(CHGMC_ST_CHARGE);
    storage = 1'b1;
    wait_mode(CHGMC_ST_STORAGE);
    chk("converter", 8'h00, {7'h00, conv_en});
    storage = 1'b0;
    wait_mode(CHGMC_ST_CHARGE);
    $display("test modes done");
    chg_pin = 1'b0;
    wait_mode(CHGMC_ST_STANDBY);
    host.wr(8'h01, 8'h01);
    repeat (1000) @(negedge clock_i);
    chk_mode(CHGMC_ST_STANDBY);
    chg_pin = 1'b1;
    wait_mode(CHGMC_ST_CHARGE);
    for (int i = 0; i < 3; i++) begin
      repeat (500) @(negedge clock_i);
      host.wr(8'h00, 8'h01);
      chk_reg(8'h00, 8'h00);
      chk_mode(CHGMC_ST_CHARGE);
    end
    repeat (600) @(negedge clock_i);
    chg_pin = 1'b0;
    wait_mode(CHGMC_ST_STANDBY);
    chg_pin = 1'b1;
    wait_mode(CHGMC_ST_CHARGE);
    repeat (600) @(negedge clock_i);
    chk_mode(CHGMC_ST_CHARGE);
    wait_mode(CHGMC_ST_FAULT);
    chk("converter", 8'h00, {7'h00, conv_en});
    host.wr(8'h00, 8'h04);
    wait_mode(CHGMC_ST_STANDBY);
    $display("test watchdog done");
    summarize();
  end
endmodule : tb_top
